// ---- slow_proto_pkg.sv ----
// Constants, types and shared functions of the slow protocol frame handler
package slow_proto_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int RATE_WINDOW_MS = 1000;
  localparam int RATE_SLOTS     = 10;
  localparam int SLOT_CYCLES    = (CLK_HZ / 1000) * RATE_WINDOW_MS / RATE_SLOTS;
  localparam logic [2:0] MAX_FRAMES_PER_WINDOW = 3'h5;

  // ----------------------------------------------------------------------
  // Addressing and protocol identification
  // ----------------------------------------------------------------------
  localparam logic [47:0] SLOW_MCAST = 48'h0180C2000002;
  localparam logic [15:0] SLOW_TYPE  = 16'h8809;
  localparam logic [15:0] VLAN_TPID  = 16'h8100;
  localparam logic [7:0]  SUB_LACP   = 8'h01;
  localparam logic [7:0]  SUB_MARKER = 8'h02;
  localparam logic [7:0]  MAX_SLOW_PROTOCOLS = 8'h0A;

  // ----------------------------------------------------------------------
  // Octet positions within a frame
  // ----------------------------------------------------------------------
  localparam logic [3:0] DA_LAST_IDX = 4'h5;
  localparam logic [3:0] TYPE_HI_IDX = 4'hC;
  localparam logic [3:0] TYPE_LO_IDX = 4'hD;
  localparam logic [3:0] SUBTYPE_IDX = 4'hE;
  localparam logic [3:0] IDX_SAT     = 4'hF;
  localparam int         RX_DELAY    = 16;

  // ----------------------------------------------------------------------
  // Frame lengths, FCS excluded (the MAC appends it)
  // ----------------------------------------------------------------------
  localparam logic [10:0] FCS_OCTETS      = 11'h004;
  localparam logic [10:0] MIN_FRAME_LEN   = 11'h040 - FCS_OCTETS;
  localparam logic [10:0] MAX_FRAME_LEN   = 11'h5EE - FCS_OCTETS;
  localparam logic [10:0] PREF_FRAME_LEN  = 11'h080 - FCS_OCTETS;
  localparam logic [10:0] LEN_SAT         = 11'h7FF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DEST_CLIENT  = 2'b00,
    DEST_LOCAL   = 2'b01,
    DEST_DISCARD = 2'b11
  } dest_e;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_FRAME = 1'b1
  } tx_state_e;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Subtype is one of the legal code points
  function automatic logic is_legal_subtype(input logic [7:0] s);
    return (s != 8'h00) && (s <= MAX_SLOW_PROTOCOLS);
  endfunction

  // Destination of a frame from its type match and subtype octet
  function automatic dest_e classify(input logic type_ok, input logic [7:0] s);
    if (!type_ok)
      return DEST_CLIENT;
    else if ((s == SUB_LACP) || (s == SUB_MARKER))
      return DEST_LOCAL;
    else if (is_legal_subtype(s))
      return DEST_CLIENT;
    else
      return DEST_DISCARD;
  endfunction

  // Octet b (0 first on the wire) of the reserved multicast address
  function automatic logic [7:0] da_byte(input logic [3:0] b);
    return SLOW_MCAST[8*(5-int'(b)) +: 8];
  endfunction

endpackage

// ---- tx_rate_limiter.sv ----
// Transmit frame rate limiter over a sliding window of time slots
`timescale 1ns/1ps
`default_nettype none
module tx_rate_limiter #(
  parameter int SLOT_CYCLES = slow_proto_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Frame start and permission
  input  wire logic frame_start,
  output logic      allow
);
  import slow_proto_pkg::*;

  typedef struct packed {
    logic [31:0]                 presc;
    logic [RATE_SLOTS:0][2:0]    slot;
    logic                        allow;
  } lim_s;

  lim_s st_reg;
  lim_s st_next;

  // Frames counted over the current slot and the full slots behind it
  function automatic logic [3:0] window_sum(input logic [RATE_SLOTS:0][2:0] s);
    logic [3:0] t;
    t = 4'h0;
    for (int i = 0; i <= RATE_SLOTS; i++)
      t = t + {1'b0, s[i]};
    return t;
  endfunction

  // Slot tick, slot shift and frame count
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.presc == 32'(SLOT_CYCLES - 1))
    begin
      st_next.presc = 32'h0;
      st_next.slot  = {st_reg.slot[RATE_SLOTS-1:0], 3'h0};
    end
    else
      st_next.presc = st_reg.presc + 32'h1;
    if (frame_start)
      st_next.slot[0] = st_next.slot[0] + 3'h1;
    // Window spans a bit more than one period, so any period stays under the cap
    st_next.allow = window_sum(st_next.slot) < {1'b0, MAX_FRAMES_PER_WINDOW};
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '{presc: 32'h0, slot: '0, allow: 1'b1};
    else
      st_reg <= st_next;
  end

  assign allow = st_reg.allow;

endmodule
`default_nettype wire

// ---- slow_protocol_frame_handler.sv ----
// Slow protocol frame classifier, receive router and transmit checker
//
// Operation
// - At most five transmitted frames per second
// - At most ten protocols share the type
// - Transmit length normal; preferably 128 octets maximum
// - Transmitted frames never carry a VLAN tag
// - Recognize 01-80-C2-00-00-02 as slow multicast
// - Only slow frames go to slow multicast
// - Type 88-09 marks slow frames, both directions
// - Subtype is first data octet; 0, 11-255 illegal
// - Subtype 1 is LACP, 2 is marker
// - Subtypes 3 to 10 legal but unsupported
// - Slow type handled whatever the destination
// - Illegal subtype frames dropped, never to client
// - Supported subtypes routed to local entity
// - Unsupported legal subtypes passed to client unchanged
`timescale 1ns/1ps
`default_nettype none
module slow_protocol_frame_handler #(
  parameter int RATE_SLOT_CYCLES = slow_proto_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Receive stream from MAC
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_sof,
  input  wire logic               rx_eof,
  // Receive stream to MAC client
  output logic                    cl_valid,
  output logic [7:0]              cl_data,
  output logic                    cl_sof,
  output logic                    cl_eof,
  // Receive stream to local protocol entities
  output logic                    lo_valid,
  output logic [7:0]              lo_data,
  output logic                    lo_sof,
  output logic                    lo_eof,
  output logic                    lo_marker,
  // Classification result
  output logic                    cls_valid,
  output slow_proto_pkg::dest_e   cls_dest,
  output logic                    cls_slow_da,
  // Transmit stream from protocol entities
  input  wire logic               txi_valid,
  input  wire logic [7:0]         txi_data,
  input  wire logic               txi_sof,
  input  wire logic               txi_eof,
  output logic                    txi_ready,
  // Transmit stream to MAC
  output logic                    txo_valid,
  output logic [7:0]              txo_data,
  output logic                    txo_sof,
  output logic                    txo_eof,
  output logic                    txo_err,
  output logic                    tx_over_pref
);
  import slow_proto_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       v;
    logic       s;
    logic       e;
    logic [7:0] d;
  } beat_s;

  typedef struct packed {
    beat_s [RX_DELAY-1:0] dly;
    logic [3:0]           idx;
    logic                 da_ok;
    logic                 type_ok;
    logic                 decided;
    dest_e                pend_dest;
    logic                 pend_marker;
    dest_e                out_dest;
    logic                 out_marker;
    logic                 cl_valid;
    logic [7:0]           cl_data;
    logic                 cl_sof;
    logic                 cl_eof;
    logic                 lo_valid;
    logic [7:0]           lo_data;
    logic                 lo_sof;
    logic                 lo_eof;
    logic                 lo_marker;
    logic                 cls_valid;
    dest_e                cls_dest;
    logic                 cls_slow_da;
    tx_state_e            tx_state;
    logic [10:0]          tx_cnt;
    logic                 tx_da_ok;
    logic [7:0]           tx_type_hi;
    logic                 tx_bad;
    logic                 txi_ready;
    logic                 txo_valid;
    logic [7:0]           txo_data;
    logic                 txo_sof;
    logic                 txo_eof;
    logic                 txo_err;
    logic                 tx_over_pref;
  } st_s;

  st_s   st_reg;
  st_s   st_next;
  logic  allow;
  logic  tx_start;
  beat_s out_beat;
  dest_e out_dest_now;

  // ----------------------------------------------------------------------
  // Transmit rate limiter
  // ----------------------------------------------------------------------
  tx_rate_limiter #(
    .SLOT_CYCLES (RATE_SLOT_CYCLES)
  ) u_rate (
    .clk         (clk),
    .nrst        (nrst),
    .frame_start (tx_start),
    .allow       (allow)
  );

  assign tx_start     = txi_valid && st_reg.txi_ready && txi_sof;
  assign out_beat     = st_reg.dly[RX_DELAY-1];
  assign out_dest_now = out_beat.s ? st_reg.pend_dest : st_reg.out_dest;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [3:0]  rb;
    logic [10:0] tb;
    logic [10:0] tlen;
    logic        tacc;
    logic        tbad;
    rb   = rx_sof ? 4'h0 : st_reg.idx;
    tb   = txi_sof ? 11'h000 : st_reg.tx_cnt;
    tlen = tb + 11'h001;
    tacc = txi_valid && st_reg.txi_ready;
    tbad = st_reg.tx_bad;
    st_next = st_reg;

    // Fixed delay line gives the decision time to arrive before octet 0 leaves
    st_next.dly = {st_reg.dly[RX_DELAY-2:0], {rx_valid, rx_sof, rx_eof, rx_data}};
    st_next.cls_valid = 1'b0;

    // Receive parser: address, type, subtype
    if (rx_valid)
    begin
      if (rb <= DA_LAST_IDX)
        st_next.da_ok = (rb == 4'h0 || st_reg.da_ok) && (rx_data == da_byte(rb));
      if (rb == 4'h0)
      begin
        st_next.decided = 1'b0;
        st_next.type_ok = 1'b0;
      end
      if (rb == TYPE_HI_IDX)
        st_next.type_ok = (rx_data == SLOW_TYPE[15:8]);
      if (rb == TYPE_LO_IDX)
        st_next.type_ok = st_reg.type_ok && (rx_data == SLOW_TYPE[7:0]);
      if (rb == SUBTYPE_IDX && !st_reg.decided)
      begin
        // Address plays no part in the decision
        st_next.pend_dest   = classify(st_reg.type_ok, rx_data);
        st_next.pend_marker = (rx_data == SUB_MARKER);
        st_next.decided     = 1'b1;
        st_next.cls_valid   = 1'b1;
        st_next.cls_dest    = classify(st_reg.type_ok, rx_data);
        st_next.cls_slow_da = st_reg.da_ok;
      end
      else if (rx_eof && rb < SUBTYPE_IDX && (rb != 4'h0 || !st_reg.decided))
      begin
        // Runt of 2 to 14 octets, or of one octet while decided is clear, ended before its subtype: hand it to the client
        st_next.pend_dest   = DEST_CLIENT;
        st_next.pend_marker = 1'b0;
        st_next.decided     = 1'b1;
        st_next.cls_valid   = 1'b1;
        st_next.cls_dest    = DEST_CLIENT;
        st_next.cls_slow_da = 1'b0;
      end
      st_next.idx = (rb < IDX_SAT) ? rb + 4'h1 : IDX_SAT;
    end

    // Receive router: destination latched as octet 0 leaves the delay line
    if (out_beat.v && out_beat.s)
    begin
      st_next.out_dest   = st_reg.pend_dest;
      st_next.out_marker = st_reg.pend_marker;
    end
    st_next.cl_valid  = out_beat.v && (out_dest_now == DEST_CLIENT);
    st_next.cl_data   = out_beat.d;
    st_next.cl_sof    = out_beat.v && out_beat.s && (out_dest_now == DEST_CLIENT);
    st_next.cl_eof    = out_beat.v && out_beat.e && (out_dest_now == DEST_CLIENT);
    st_next.lo_valid  = out_beat.v && (out_dest_now == DEST_LOCAL);
    st_next.lo_data   = out_beat.d;
    st_next.lo_sof    = out_beat.v && out_beat.s && (out_dest_now == DEST_LOCAL);
    st_next.lo_eof    = out_beat.v && out_beat.e && (out_dest_now == DEST_LOCAL);
    st_next.lo_marker = out_beat.s ? st_reg.pend_marker : st_reg.out_marker;

    // Transmit checker: octets pass one cycle late; a bad frame ends with txo_err
    st_next.txo_valid    = tacc;
    st_next.txo_data     = txi_data;
    st_next.txo_sof      = tacc && txi_sof;
    st_next.txo_eof      = tacc && txi_eof;
    st_next.txo_err      = 1'b0;
    st_next.tx_over_pref = 1'b0;
    if (tacc)
    begin
      if (tb == 11'h000)
        tbad = !txi_sof;
      if (tb <= {7'h00, DA_LAST_IDX})
        st_next.tx_da_ok = (tb == 11'h000 || st_reg.tx_da_ok)
                           && (txi_data == da_byte(tb[3:0]));
      if (tb == {7'h00, TYPE_HI_IDX})
        st_next.tx_type_hi = txi_data;
      if (tb == {7'h00, TYPE_LO_IDX})
      begin
        if ({st_reg.tx_type_hi, txi_data} == VLAN_TPID)
          tbad = 1'b1;
        if ({st_reg.tx_type_hi, txi_data} != SLOW_TYPE)
          tbad = 1'b1;
        // Reserved multicast carries slow frames only
        if (st_reg.tx_da_ok && ({st_reg.tx_type_hi, txi_data} != SLOW_TYPE))
          tbad = 1'b1;
      end
      st_next.tx_cnt = (tb < LEN_SAT) ? tlen : LEN_SAT;
      if (txi_eof)
      begin
        if (tlen < MIN_FRAME_LEN || tlen > MAX_FRAME_LEN)
          tbad = 1'b1;
        st_next.txo_err      = tbad;
        st_next.tx_over_pref = (tlen > PREF_FRAME_LEN);
        st_next.tx_state     = TX_IDLE;
        // Restart the count so a frame lacking its start flag is caught
        st_next.tx_cnt       = 11'h000;
        tbad = 1'b0;
      end
      else if (txi_sof)
        st_next.tx_state = TX_FRAME;
    end
    st_next.tx_bad = tbad;
    // Hold back a new frame until the window has room
    st_next.txi_ready = (st_next.tx_state == TX_FRAME) || (allow && !tx_start);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg           <= '0;
      st_reg.tx_state  <= TX_IDLE;
      st_reg.pend_dest <= DEST_CLIENT;
      st_reg.out_dest  <= DEST_CLIENT;
      st_reg.cls_dest  <= DEST_CLIENT;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the register
  assign cl_valid     = st_reg.cl_valid;
  assign cl_data      = st_reg.cl_data;
  assign cl_sof       = st_reg.cl_sof;
  assign cl_eof       = st_reg.cl_eof;
  assign lo_valid     = st_reg.lo_valid;
  assign lo_data      = st_reg.lo_data;
  assign lo_sof       = st_reg.lo_sof;
  assign lo_eof       = st_reg.lo_eof;
  assign lo_marker    = st_reg.lo_marker;
  assign cls_valid    = st_reg.cls_valid;
  assign cls_dest     = st_reg.cls_dest;
  assign cls_slow_da  = st_reg.cls_slow_da;
  assign txi_ready    = st_reg.txi_ready;
  assign txo_valid    = st_reg.txo_valid;
  assign txo_data     = st_reg.txo_data;
  assign txo_sof      = st_reg.txo_sof;
  assign txo_eof      = st_reg.txo_eof;
  assign txo_err      = st_reg.txo_err;
  assign tx_over_pref = st_reg.tx_over_pref;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_rate_hold;
    @(posedge clk) disable iff (!nrst)
    (st_reg.tx_state == TX_IDLE && !allow) |-> !tx_start;
  endproperty
  a_rate_hold: assert property (p_rate_hold)
    else $error("new frame admitted while the rate window is full");

  property p_illegal_drop;
    @(posedge clk) disable iff (!nrst)
    (rx_valid && !rx_sof && st_reg.idx == SUBTYPE_IDX && !st_reg.decided && st_reg.type_ok
     && !is_legal_subtype(rx_data)) |=> (cls_valid && cls_dest == DEST_DISCARD);
  endproperty
  a_illegal_drop: assert property (p_illegal_drop)
    else $error("illegal subtype not classified as discard");

  property p_lacp_local;
    @(posedge clk) disable iff (!nrst)
    (rx_valid && !rx_sof && st_reg.idx == SUBTYPE_IDX && !st_reg.decided && st_reg.type_ok
     && rx_data == SUB_LACP) |=> (cls_dest == DEST_LOCAL && !st_reg.pend_marker);
  endproperty
  a_lacp_local: assert property (p_lacp_local)
    else $error("LACP subtype not routed locally");

  property p_reserved_client;
    @(posedge clk) disable iff (!nrst)
    (rx_valid && !rx_sof && st_reg.idx == SUBTYPE_IDX && !st_reg.decided && st_reg.type_ok
     && rx_data > SUB_MARKER && rx_data <= MAX_SLOW_PROTOCOLS) |=> (cls_dest == DEST_CLIENT);
  endproperty
  a_reserved_client: assert property (p_reserved_client)
    else $error("reserved subtype not passed to client");

  property p_other_type_client;
    @(posedge clk) disable iff (!nrst)
    (rx_valid && !rx_sof && st_reg.idx == SUBTYPE_IDX && !st_reg.decided && !st_reg.type_ok)
    |=> (cls_valid && cls_dest == DEST_CLIENT);
  endproperty
  a_other_type_client: assert property (p_other_type_client)
    else $error("non slow frame not passed to client");

  property p_discard_silent;
    @(posedge clk) disable iff (!nrst)
    (out_beat.v && out_beat.s && st_reg.pend_dest == DEST_DISCARD)
    |=> (!cl_valid && !lo_valid) [*2];
  endproperty
  a_discard_silent: assert property (p_discard_silent)
    else $error("discarded frame reached an output");

  property p_latency;
    @(posedge clk) disable iff (!nrst)
    (rx_valid && rx_sof) |-> ##17 (cl_sof || lo_sof || st_reg.out_dest == DEST_DISCARD);
  endproperty
  a_latency: assert property (p_latency)
    else $error("frame start not delivered after the fixed delay");

  property p_tx_bad_err;
    @(posedge clk) disable iff (!nrst)
    (st_reg.tx_bad && txi_valid && st_reg.txi_ready && txi_eof) |=> (txo_err && txo_eof);
  endproperty
  a_tx_bad_err: assert property (p_tx_bad_err)
    else $error("bad transmit frame ended without error");

  property p_tx_long;
    @(posedge clk) disable iff (!nrst)
    (txi_valid && st_reg.txi_ready && txi_eof && !txi_sof && st_reg.tx_cnt >= PREF_FRAME_LEN)
    |=> tx_over_pref;
  endproperty
  a_tx_long: assert property (p_tx_long)
    else $error("over long transmit frame not flagged");

endmodule
`default_nettype wire

// ---- slow_tx_entity.sv ----
// Frame source standing in for the protocol entity on the transmit side
`timescale 1ns/1ps
`default_nettype none
module slow_tx_entity (
  // Clock and handshake
  input  wire logic        clk,
  input  wire logic        txi_ready,
  // Frame request
  input  wire logic        go,
  input  wire logic [10:0] len,
  input  wire logic [15:0] typ,
  input  wire logic        mc,
  // Transmit stream
  output logic             txi_valid,
  output logic [7:0]       txi_data,
  output logic             txi_sof,
  output logic             txi_eof,
  output logic             busy
);
  logic [10:0] idx;
  logic        taken;

  // Octet at position i: address, counting pattern, type, subtype 1, then a counting pattern
  function automatic logic [7:0] oct(input logic [10:0] i);
    logic [47:0] da;
    da = mc ? 48'h0180C2000002 : 48'h020000000001;
    if (i < 11'h006)
      return da[8*(5-int'(i)) +: 8];
    if (i == 11'h00C)
      return typ[15:8];
    if (i == 11'h00D)
      return typ[7:0];
    return (i == 11'h00E) ? 8'h01 : i[7:0];
  endfunction

  // Idle at time zero
  initial
  begin
    busy      = 1'b0;
    idx       = 11'h000;
    taken     = 1'b0;
    txi_valid = 1'b0;
    txi_sof   = 1'b0;
    txi_eof   = 1'b0;
    txi_data  = 8'h5A;
  end

  // Note whether the octet on the lines was taken at this edge
  always @(posedge clk)
    taken <= txi_valid && txi_ready;

  // Advance only after a taken octet; released data toggles every cycle
  always @(negedge clk)
  begin
    if (taken && txi_eof)
      busy = 1'b0;
    else if (taken)
      idx = idx + 11'h001;
    if (go && !busy)
    begin
      busy = 1'b1;
      idx  = 11'h000;
    end
    txi_valid = busy;
    txi_sof   = busy && (idx == 11'h000);
    txi_eof   = busy && (idx == len - 11'h001);
    txi_data  = busy ? oct(idx) : ~txi_data;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the slow protocol frame handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import slow_proto_pkg::*;
  localparam int SLOT = 20;
  typedef struct packed {logic [15:0] typ; logic [7:0] sub; logic mc; dest_e dest;} rx_s;
  typedef struct packed {logic [10:0] len; logic [15:0] typ; logic mc; logic err; logic over;} tx_s;
  logic        clk = 1'b0;
  logic        nrst, rx_valid, rx_sof, rx_eof, go, t_mc, busy;
  logic [7:0]  rx_data, cl_data, lo_data, txi_data, txo_data, td1;
  logic        cl_valid, cl_sof, cl_eof, lo_valid, lo_sof, lo_eof, lo_marker;
  logic        cls_valid, cls_slow_da, txi_valid, txi_sof, txi_eof, txi_ready;
  logic        txo_valid, txo_sof, txo_eof, txo_err, tx_over_pref, last_err, last_over;
  logic        tk1, ts1;
  logic [10:0] t_len;
  logic [15:0] t_typ;
  dest_e       cls_dest;
  rx_s         cur;
  int          errors, n_compared, ncl, nlo, ncls, pos, cyc, rx_len;
  int          sof_t[$];
  rx_s rxt [9] = '{'{16'h8809, 8'h00, 1'b1, DEST_DISCARD}, '{16'h8809, 8'h01, 1'b1, DEST_LOCAL},
    '{16'h8809, 8'h02, 1'b0, DEST_LOCAL}, '{16'h8809, 8'h03, 1'b1, DEST_CLIENT},
    '{16'h8809, 8'h0A, 1'b0, DEST_CLIENT}, '{16'h8809, 8'h0B, 1'b1, DEST_DISCARD},
    '{16'h8809, 8'hFF, 1'b1, DEST_DISCARD}, '{16'h0800, 8'h00, 1'b1, DEST_CLIENT},
    '{16'h8909, 8'h01, 1'b0, DEST_CLIENT}};
  tx_s txt [8] = '{'{11'h03C, 16'h8809, 1'b1, 1'b0, 1'b0}, '{11'h07C, 16'h8809, 1'b1, 1'b0, 1'b0},
    '{11'h07D, 16'h8809, 1'b0, 1'b0, 1'b1}, '{11'h03B, 16'h8809, 1'b1, 1'b1, 1'b0},
    '{11'h5EA, 16'h8809, 1'b1, 1'b0, 1'b1}, '{11'h5EB, 16'h8809, 1'b1, 1'b1, 1'b1},
    '{11'h03C, 16'h8100, 1'b1, 1'b1, 1'b0}, '{11'h03C, 16'h0800, 1'b1, 1'b1, 1'b0}};

  // Clock of 100 ns
  always #50 clk = ~clk;

  slow_protocol_frame_handler #(.RATE_SLOT_CYCLES(SLOT)) i_slow_protocol_frame_handler (
    .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .cl_valid(cl_valid), .cl_data(cl_data), .cl_sof(cl_sof), .cl_eof(cl_eof),
    .lo_valid(lo_valid), .lo_data(lo_data), .lo_sof(lo_sof), .lo_eof(lo_eof),
    .lo_marker(lo_marker), .cls_valid(cls_valid), .cls_dest(cls_dest),
    .cls_slow_da(cls_slow_da), .txi_valid(txi_valid), .txi_data(txi_data), .txi_sof(txi_sof),
    .txi_eof(txi_eof), .txi_ready(txi_ready), .txo_valid(txo_valid), .txo_data(txo_data),
    .txo_sof(txo_sof), .txo_eof(txo_eof), .txo_err(txo_err), .tx_over_pref(tx_over_pref));

  slow_tx_entity i_slow_tx_entity (.clk(clk), .txi_ready(txi_ready), .go(go), .len(t_len),
    .typ(t_typ), .mc(t_mc), .txi_valid(txi_valid), .txi_data(txi_data), .txi_sof(txi_sof),
    .txi_eof(txi_eof), .busy(busy));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Receive octet i of a test frame (20 octets, or 10 for the runt)
  function automatic logic [7:0] rx_oct(input int i, input rx_s r);
    logic [47:0] da;
    da = r.mc ? 48'h0180C2000002 : 48'h020000000001;
    if (i < 6)
      return da[8*(5-i) +: 8];
    if (i == 12)
      return r.typ[15:8];
    if (i == 13)
      return r.typ[7:0];
    return (i == 14) ? r.sub : 8'(i + 8'h30);
  endfunction

  task automatic send_rx(input rx_s r);
    for (int i = 0; i < rx_len; i++)
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_sof   = (i == 0);
      rx_eof   = (i == rx_len - 1);
      rx_data  = rx_oct(i, r);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_eof   = 1'b0;
    rx_data  = ~rx_data;
  endtask

  task automatic send_tx(input tx_s r);
    int n;
    n = 0;
    @(negedge clk);
    {t_len, t_typ, t_mc, go} = {r.len, r.typ, r.mc, 1'b1};
    last_err = ~r.err;
    while (!busy && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    go = 1'b0;
    while (busy && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000 || n < 10)
    begin
      errors++;
      test_done();
    end
    repeat (2) @(negedge clk);
    check(last_err === r.err, "tx error flag");
    check(last_over === r.over, "tx oversize flag");
  endtask

  // ----------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------
  // Octet taken on transmit at this edge
  always @(posedge clk)
  begin
    cyc++;
    {tk1, td1, ts1} = {txi_valid && txi_ready, txi_data, txi_sof};
  end

  // Outputs sampled half a cycle after the edge
  always @(negedge clk)
  begin
    if (cls_valid)
    begin
      ncls++;
      check(cls_dest === cur.dest, "class destination");
      check(cls_slow_da === cur.mc, "slow address flag");
      check(rx_valid === 1'b1 || rx_len < 15, "class after frame end");
    end
    if (cl_valid || lo_valid)
    begin
      if (cl_sof || lo_sof)
        pos = 0;
      check((cl_valid ? cl_data : lo_data) === rx_oct(pos, cur), "routed octet");
      if (lo_valid)
        check(lo_marker === (cur.sub == 8'h02), "marker flag");
      if (cl_eof || lo_eof)
        check(pos == rx_len - 1, "frame end");
      pos++;
      ncl += int'(cl_valid);
      nlo += int'(lo_valid);
    end
    if (tk1)
      check(txo_valid === 1'b1 && txo_data === td1 && txo_sof === ts1, "tx copy");
    if (txo_valid && txo_sof)
      sof_t.push_back(cyc);
    if (txo_valid && txo_eof)
      {last_err, last_over} = {txo_err, tx_over_pref};
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {nrst, rx_valid, rx_sof, rx_eof, go, rx_data} = 13'h000;
    {t_len, t_typ, t_mc} = {11'h03C, 16'h8809, 1'b1};
    {tk1, td1, ts1} = 10'h000;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    rx_len = 20;
    foreach (rxt[k])
    begin
      cur = rxt[k];
      {ncl, nlo, ncls} = {32'd0, 32'd0, 32'd0};
      send_rx(cur);
      repeat (40) @(negedge clk);
      check(ncls == 1, "one classification");
      check(ncl == ((cur.dest == DEST_CLIENT) ? 20 : 0), "client octets");
      check(nlo == ((cur.dest == DEST_LOCAL) ? 20 : 0), "local octets");
    end
    // Runt that ends before its subtype goes to the client as it stands
    rx_len = 10;
    cur    = '{16'h8809, 8'h01, 1'b0, DEST_CLIENT};
    {ncl, nlo, ncls} = {32'd0, 32'd0, 32'd0};
    send_rx(cur);
    repeat (40) @(negedge clk);
    check(ncls == 1 && ncl == 10 && nlo == 0, "runt to client");
    foreach (txt[k])
      send_tx(txt[k]);
    repeat (6) send_tx('{11'h010, 16'h8809, 1'b1, 1'b1, 1'b0});
    for (int i = 0; i + 5 < sof_t.size(); i++)
      check(sof_t[i+5] - sof_t[i] >= 10 * SLOT, "rate window");
    nrst = 1'b0;
    @(negedge clk);
    check(txi_ready === 1'b0 && cls_dest === DEST_CLIENT && txo_valid === 1'b0, "reset");
    nrst = 1'b1;
    @(negedge clk);
    check(txi_ready === 1'b1, "window empty after reset");
    test_done();
  end
endmodule
`default_nettype wire
